// File: design/supervisor_pkg.sv
// Purpose: constants and types for the drive run supervisor
// Assumes: 125 MHz pclk, APB register access, 32-bit aligned words
// Notes: frequencies in 0.01 Hz, ramp times in 0.1 s, restart delay in ms
//
// Operation
// - fan fault policy 0 keeps the motor running on a fan fault.
// - relay function 18 drives the relay while the fan fault is present.
// - fan fault policy 1 stops the drive and shows a fault code.
// - with policy 1, relay function 17 reports the fan fault as a fault.
// - below the switch frequency use low-band ramps, else normal; low-band default 10.0 s.
// - digital input function 28 enters fire mode; relay function 27 shows it.
// - fire mode forces V/f control whatever method was configured.
// - fire mode runs at the emergency frequency, default 50.00 Hz, above jog.
// - fire mode uses fixed 10 s ramps that software cannot change.
// - fire mode ignores and hides the listed protective faults.
// - fire mode auto-restarts on OC, OV, LV, ground fault without retry limit.
// - fire mode never restarts after a hardware or keypad fault.
// - relay selectors accept 0 to 27; defaults 12 and 17.
package supervisor_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RELAY_OFS = 8'h04;
  localparam logic [7:0] DIN_OFS = 8'h08;
  localparam logic [7:0] FREQ_OFS = 8'h0C;
  localparam logic [7:0] NRAMP_OFS = 8'h10;
  localparam logic [7:0] LRAMP_OFS = 8'h14;
  localparam logic [7:0] SWFREQ_OFS = 8'h18;
  localparam logic [7:0] EFREQ_OFS = 8'h1C;
  localparam logic [7:0] RESTART_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;
  localparam logic [7:0] INT_STATUS_OFS = 8'h28;
  localparam logic [7:0] INT_MASK_OFS = 8'h2C;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [4:0] RELAY1_RESET = 5'h0C;
  localparam logic [4:0] RELAY2_RESET = 5'h11;
  localparam logic [4:0] RELAY_MAX = 5'h1B;
  localparam logic [4:0] FN_FAULT_OUT = 5'h11;
  localparam logic [4:0] FN_FAN_ALARM = 5'h12;
  localparam logic [4:0] FN_FIRE_OUT = 5'h1B;
  localparam logic [7:0] FN_FIRE_IN = 8'h1C;
  localparam logic [15:0] LOW_RAMP_RESET = 16'h0064;
  localparam logic [15:0] NORM_RAMP_RESET = 16'h0032;
  localparam logic [15:0] FIRE_RAMP = 16'h0064;
  localparam logic [15:0] EFREQ_RESET = 16'h1388;
  localparam logic [1:0] METHOD_VF = 2'h0;
  localparam logic [1:0] POLICY_RUN = 2'h0;
  // ----------------------------------------------------------------
  // fault vector layout
  // ----------------------------------------------------------------
  localparam int FAN_BIT = 2;
  localparam logic [15:0] FIRE_IGNORE = 16'h03FF;
  localparam logic [15:0] AUTO_RESTART = 16'h3C00;
  localparam logic [15:0] NO_RESTART = 16'hC000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESTART_UNIT_NS = 1000000;
  localparam int MS_CYCLES = RESTART_UNIT_NS / CLK_PERIOD_NS;
  localparam int IRQ_W = 5;

  typedef struct packed {
    logic run;
    logic vf_mode;
    logic [1:0] method;
    logic [15:0] freq_ref;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
  } drive_cmd_s;

  typedef enum logic {RS_IDLE, RS_WAIT} restart_e;
endpackage : supervisor_pkg

// File: design/drive_run_supervisor.sv
// Purpose: fan fault policy, ramp selection, fire mode and fault restart
// Assumes: pins and fault inputs are asynchronous; oper_freq is on pclk
// Notes: zero-wait APB slave, read data captured in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module drive_run_supervisor
  import supervisor_pkg::*;
#(
  parameter int MS_TICK = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] din,
  input wire logic [15:0] fault_in,
  input wire logic [15:0] oper_freq,
  output drive_cmd_s drive_cmd,
  output logic relay1,
  output logic relay2,
  output logic [4:0] fault_code,
  output logic restart_pulse,
  output logic irq
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [4:0] first_fault(input logic [15:0] f);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (f[i]) c = 5'(i + 1);
    end
    return c;
  endfunction : first_fault

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [19:0] sync1_reg;
  logic [19:0] sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 20'h00000;
      sync2_reg <= 20'h00000;
    end else begin
      sync1_reg <= {din, fault_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic [3:0] din_s;
  logic [15:0] fault_s;
  assign din_s = sync2_reg[19:16];
  assign fault_s = sync2_reg[15:0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0] ctrl_reg;
  logic [4:0] relay1_function;
  logic [4:0] relay2_function;
  logic [31:0] din_func_reg;
  logic [31:0] freq_reg;
  logic [31:0] nramp_reg;
  logic [31:0] lramp_reg;
  logic [15:0] ramp_switch_frequency;
  logic [15:0] emergency_run_frequency;
  logic [23:0] restart_reg;
  logic [IRQ_W-1:0] int_status_reg;
  logic [IRQ_W-1:0] int_mask_reg;
  logic [IRQ_W-1:0] events;
  logic [7:0] retry_reg;
  logic [15:0] fault_latch_reg;
  logic fire;
  logic mapped;
  logic wr;
  logic [31:0] wv;
  logic [31:0] rd_next;
  logic [31:0] status;

  assign wr = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= INT_MASK_OFS);

  always_comb begin
    wv = 32'h00000000;
    unique case (paddr)
      CTRL_OFS: wv = {23'h000000, ctrl_reg};
      RELAY_OFS: wv = {19'h00000, relay2_function, 3'h0, relay1_function};
      DIN_OFS: wv = din_func_reg;
      FREQ_OFS: wv = freq_reg;
      NRAMP_OFS: wv = nramp_reg;
      LRAMP_OFS: wv = lramp_reg;
      SWFREQ_OFS: wv = {16'h0000, ramp_switch_frequency};
      EFREQ_OFS: wv = {16'h0000, emergency_run_frequency};
      RESTART_OFS: wv = {8'h00, restart_reg};
      STATUS_OFS: wv = status;
      INT_STATUS_OFS: wv = {27'h0000000, int_status_reg};
      INT_MASK_OFS: wv = {27'h0000000, int_mask_reg};
      default: wv = 32'h00000000;
    endcase
    rd_next = merge(wv, pwdata, pstrb);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= wv;
    end
  end

  logic [31:0] relay_new;
  assign relay_new = rd_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 9'h000;
      relay1_function <= RELAY1_RESET;
      relay2_function <= RELAY2_RESET;
      din_func_reg <= 32'h00000000;
      freq_reg <= 32'h00000000;
      nramp_reg <= {NORM_RAMP_RESET, NORM_RAMP_RESET};
      lramp_reg <= {LOW_RAMP_RESET, LOW_RAMP_RESET};
      ramp_switch_frequency <= 16'h0000;
      emergency_run_frequency <= EFREQ_RESET;
      restart_reg <= 24'h000000;
      int_mask_reg <= 5'h00;
    end else begin
      ctrl_reg[8] <= 1'b0; // fault reset is a self-clearing strobe
      if (wr) begin
        unique case (paddr)
          CTRL_OFS: ctrl_reg <= rd_next[8:0];
          RELAY_OFS: begin
            // out-of-range selectors are dropped, the old function stays
            if (relay_new[4:0] <= RELAY_MAX) relay1_function <= relay_new[4:0];
            if (relay_new[12:8] <= RELAY_MAX) relay2_function <= relay_new[12:8];
          end
          DIN_OFS: din_func_reg <= rd_next;
          FREQ_OFS: freq_reg <= rd_next;
          NRAMP_OFS: nramp_reg <= rd_next;
          LRAMP_OFS: lramp_reg <= rd_next;
          SWFREQ_OFS: ramp_switch_frequency <= rd_next[15:0];
          EFREQ_OFS: emergency_run_frequency <= rd_next[15:0];
          RESTART_OFS: restart_reg <= rd_next[23:0];
          INT_MASK_OFS: int_mask_reg <= rd_next[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fire mode
  // ----------------------------------------------------------------
  logic fire_reg;
  always_comb begin
    fire = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (din_s[i] && din_func_reg[i*8 +: 8] == FN_FIRE_IN) fire = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fault handling
  // ----------------------------------------------------------------
  logic [15:0] live;
  logic [15:0] trips;
  logic fan_alarm;
  logic fault_active;
  logic fault_reset;
  logic restart_ok;
  logic restart_done;
  restart_e rs_reg;
  logic [15:0] delay_ms_reg;
  logic [$clog2(MS_TICK+1)-1:0] tick_reg;

  assign fault_reset = ctrl_reg[8];
  // hidden faults are neither latched nor shown while fire mode holds
  assign live = fault_s & ~(fire ? FIRE_IGNORE : 16'h0000);
  // policy 0 keeps running: the fan fault never becomes a trip
  assign trips = live & ~((ctrl_reg[2] == POLICY_RUN[0]) ? (16'h0001 << FAN_BIT) : 16'h0000);
  assign fan_alarm = live[FAN_BIT];
  assign fault_active = |fault_latch_reg;
  assign fault_code = first_fault(fault_latch_reg);
  assign restart_ok = fault_active && ((fault_latch_reg & ~AUTO_RESTART) == 16'h0000)
                      && ((fault_latch_reg & NO_RESTART) == 16'h0000)
                      && (fire || retry_reg < restart_reg[23:16]);
  assign restart_done = (rs_reg == RS_WAIT) && (delay_ms_reg >= restart_reg[15:0])
                        && restart_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_latch_reg <= 16'h0000;
    end else if (restart_done || fault_reset) begin
      fault_latch_reg <= trips; // a fault still present re-trips at once
    end else begin
      // fire mode clears faults it is told to ignore
      fault_latch_reg <= (fault_latch_reg & ~(fire ? FIRE_IGNORE : 16'h0000)) | trips;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_reg <= RS_IDLE;
      delay_ms_reg <= 16'h0000;
      tick_reg <= '0;
    end else begin
      unique case (rs_reg)
        RS_IDLE: begin
          delay_ms_reg <= 16'h0000;
          tick_reg <= '0;
          if (restart_ok) rs_reg <= RS_WAIT;
        end
        RS_WAIT: begin
          if (!restart_ok || restart_done) begin
            rs_reg <= RS_IDLE;
          end else if (tick_reg == ($bits(tick_reg))'(MS_TICK - 1)) begin
            tick_reg <= '0;
            delay_ms_reg <= delay_ms_reg + 16'h0001;
          end else begin
            tick_reg <= tick_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_reg <= 8'h00;
      restart_pulse <= 1'b0;
    end else begin
      restart_pulse <= restart_done;
      if (fault_reset) retry_reg <= 8'h00;
      else if (restart_done && retry_reg != 8'hFF) retry_reg <= retry_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // drive command and relays
  // ----------------------------------------------------------------
  logic low_band;
  assign low_band = oper_freq < ramp_switch_frequency;

  function automatic logic relay_drive(input logic [4:0] fn, input logic fa, input logic fan,
                                       input logic fm);
    return (fn == FN_FAULT_OUT && fa) || (fn == FN_FAN_ALARM && fan) || (fn == FN_FIRE_OUT && fm);
  endfunction : relay_drive

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cmd <= '0;
      relay1 <= 1'b0;
      relay2 <= 1'b0;
      fire_reg <= 1'b0;
    end else begin
      fire_reg <= fire;
      // stop on a latched trip; with policy 1 the fan fault is one of them
      drive_cmd.run <= ctrl_reg[0] && !fault_active;
      drive_cmd.vf_mode <= fire || ctrl_reg[4:3] == METHOD_VF;
      drive_cmd.method <= fire ? METHOD_VF : ctrl_reg[4:3];
      if (fire) drive_cmd.freq_ref <= emergency_run_frequency;
      else if (ctrl_reg[1]) drive_cmd.freq_ref <= freq_reg[31:16];
      else drive_cmd.freq_ref <= freq_reg[15:0];
      if (fire) begin
        drive_cmd.accel_time <= FIRE_RAMP;
        drive_cmd.decel_time <= FIRE_RAMP;
      end else if (low_band) begin
        drive_cmd.accel_time <= lramp_reg[15:0];
        drive_cmd.decel_time <= lramp_reg[31:16];
      end else begin
        drive_cmd.accel_time <= nramp_reg[15:0];
        drive_cmd.decel_time <= nramp_reg[31:16];
      end
      relay1 <= relay_drive(relay1_function, fault_active, fan_alarm, fire);
      relay2 <= relay_drive(relay2_function, fault_active, fan_alarm, fire);
    end
  end

  // ----------------------------------------------------------------
  // status and interrupts
  // ----------------------------------------------------------------
  logic fan_d_reg;
  logic fault_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_d_reg <= 1'b0;
      fault_d_reg <= 1'b0;
    end else begin
      fan_d_reg <= fan_alarm;
      fault_d_reg <= fault_active;
    end
  end

  assign events = {restart_done, fan_alarm && !fan_d_reg, fault_active && !fault_d_reg,
                   fire_reg && !fire, fire && !fire_reg};
  assign status = {8'h00, retry_reg, 3'h0, fault_code, 2'h0, low_band, relay2, relay1,
                   fault_active, drive_cmd.run, fire_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= 5'h00;
    end else begin
      // a new event wins over a write-one-to-clear in the same cycle
      if (wr && paddr == INT_STATUS_OFS) begin
        int_status_reg <= (int_status_reg & ~rd_next[IRQ_W-1:0]) | events;
      end else begin
        int_status_reg <= int_status_reg | events;
      end
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);
endmodule : drive_run_supervisor
`default_nettype wire

// File: test/drive_run_supervisor_assertions.sv
// Purpose: port checks of the run supervisor
// Assumes: apb writes carry full strobes
// Notes: mirrors a few registers from bus writes
`timescale 1ns/1ps
`default_nettype none
module drive_run_supervisor_assertions
  import supervisor_pkg::*;
#(
  parameter int MS_TICK = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [3:0] din,
  input wire logic [15:0] fault_in,
  input wire drive_cmd_s drive_cmd,
  input wire logic relay2,
  input wire logic [4:0] fault_code,
  input wire logic restart_pulse
);
  // ----
  // mirrors, kept as counters so lag needs no exact figure
  // ----
  logic [31:0] fn_reg;
  logic [4:0] r2_reg;
  logic [3:0] d1_reg, d2_reg;
  logic f1_reg, f2_reg, wr, fire;
  logic [2:0] fire_cnt, fan_cnt;
  assign wr = psel && penable && pwrite;
  always_comb begin
    fire = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (d2_reg[i] && fn_reg[8*i+:8] == FN_FIRE_IN) fire = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn_reg <= 32'h0;
      r2_reg <= RELAY2_RESET;
    end else if (wr && paddr == DIN_OFS) begin
      fn_reg <= pwdata;
    end else if (wr && paddr == RELAY_OFS && pwdata[12:8] <= RELAY_MAX) begin
      r2_reg <= pwdata[12:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {d1_reg, d2_reg, f1_reg, f2_reg} <= 10'h0;
      fire_cnt <= 3'h0;
      fan_cnt <= 3'h0;
    end else begin
      d1_reg <= din;
      d2_reg <= d1_reg;
      f1_reg <= fault_in[FAN_BIT];
      f2_reg <= f1_reg;
      fire_cnt <= !fire ? 3'h0 : (fire_cnt == 3'h7 ? fire_cnt : fire_cnt + 3'h1);
      fan_cnt <= !f2_reg ? 3'h0 : (fan_cnt == 3'h7 ? fan_cnt : fan_cnt + 3'h1);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_slverr_map;
    psel && penable && paddr > INT_MASK_OFS |-> pslverr;
  endproperty
  a_slverr_map: assert property (p_slverr_map) else $error("unmapped access not refused");
  property p_slverr_idle;
    !(psel && penable) |-> !pslverr;
  endproperty
  a_slverr_idle: assert property (p_slverr_idle) else $error("error outside access");
  property p_fault_stop;
    (fault_code != 5'h00) [*2] |-> !drive_cmd.run;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("runs with latched fault");
  property p_restart_one;
    restart_pulse |=> !restart_pulse;
  endproperty
  a_restart_one: assert property (p_restart_one) else $error("restart pulse too long");
  property p_fan_alarm;
    fan_cnt >= 3'h3 && fire_cnt == 3'h0 && !$past(fire) && r2_reg == FN_FAN_ALARM
      && $stable(r2_reg) |-> relay2;
  endproperty
  a_fan_alarm: assert property (p_fan_alarm) else $error("fan alarm relay low");
  property p_fire_relay;
    fire_cnt >= 3'h3 && r2_reg == FN_FIRE_OUT && $stable(r2_reg) |-> relay2;
  endproperty
  a_fire_relay: assert property (p_fire_relay) else $error("fire relay low");
  property p_fire_ramp;
    fire_cnt >= 3'h3 |-> drive_cmd.vf_mode && drive_cmd.method == METHOD_VF
      && drive_cmd.accel_time == FIRE_RAMP && drive_cmd.decel_time == FIRE_RAMP;
  endproperty
  a_fire_ramp: assert property (p_fire_ramp) else $error("fire ramp or mode wrong");
  property p_fire_hide;
    fire_cnt >= 3'h3 |-> fault_code == 5'h00 || fault_code > 5'h0A;
  endproperty
  a_fire_hide: assert property (p_fire_hide) else $error("hidden fault shown");
endmodule : drive_run_supervisor_assertions
bind drive_run_supervisor drive_run_supervisor_assertions #(.MS_TICK(MS_TICK)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .din(din), .fault_in(fault_in),
  .drive_cmd(drive_cmd), .relay2(relay2), .fault_code(fault_code),
  .restart_pulse(restart_pulse));
`default_nettype wire

// File: test/power_stage_model.sv
// Purpose: power stage stand-in, echoes trips and motor speed
// Assumes: speed follows the run command at once
// Notes: no ramp, keeps the bench short
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
  import supervisor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire drive_cmd_s drive_cmd,
  input wire logic [15:0] trip_req,
  input wire logic [15:0] speed_req,
  output logic [15:0] fault_in,
  output logic [15:0] oper_freq
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_in <= 16'h0000;
      oper_freq <= 16'h0000;
    end else begin
      fault_in <= trip_req;
      oper_freq <= drive_cmd.run ? speed_req : 16'h0000;
    end
  end
endmodule : power_stage_model
`default_nettype wire

// File: test/drive_run_supervisor_test.sv
// Purpose: directed test over apb and pins
// Assumes: MS_TICK of 4, one restart ms is four cycles
// Notes: sticky fault inputs need a few cycles to settle
`timescale 1ns/1ps
`default_nettype none
module drive_run_supervisor_test
  import supervisor_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, relay1, relay2, rp, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] din;
  logic [15:0] trip_req, speed_req, fault_in, oper_freq;
  logic [4:0] fault_code;
  drive_cmd_s cmd;
  int n_mismatch, num_checks, k;
  drive_run_supervisor #(.MS_TICK(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .fault_in(fault_in), .oper_freq(oper_freq),
    .drive_cmd(cmd), .relay1(relay1), .relay2(relay2), .fault_code(fault_code),
    .restart_pulse(rp), .irq(irq));
  power_stage_model u_pwr (
    .pclk(pclk), .presetn(presetn), .drive_cmd(cmd), .trip_req(trip_req),
    .speed_req(speed_req), .fault_in(fault_in), .oper_freq(oper_freq));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // ----
  // apb master, holds the request until pready is seen
  // ----
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      n_mismatch++;
      $display("[ERR] %0t apb timeout", $time);
      end_sim();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic pulses(input int c);
    k = 0;
    repeat (c) begin
      @(posedge pclk);
      if (rp === 1'b1) k++;
    end
  endtask : pulses
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    din = 4'h0;
    trip_req = 16'h0;
    speed_req = 16'h0;
    cyc(20);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(RELAY_OFS, 32'h0000_110C);
    rd(LRAMP_OFS, 32'h0064_0064);
    rd(EFREQ_OFS, 32'h0000_1388);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1'b1);
    $display("test defaults done");
    apb(1'b1, CTRL_OFS, 32'h01);
    apb(1'b1, SWFREQ_OFS, 32'h03E8);
    speed_req <= 16'h01F4;
    cyc(6);
    chk(cmd.accel_time, LOW_RAMP_RESET);
    speed_req <= 16'h07D0;
    cyc(6);
    chk(cmd.decel_time, NORM_RAMP_RESET);
    $display("test ramp done");
    apb(1'b1, RELAY_OFS, 32'h1211);
    trip_req <= 16'h0004;
    cyc(6);
    chk(cmd.run, 1'b1);
    chk(relay2, 1'b1);
    chk(fault_code, 5'h00);
    trip_req <= 16'h0000;
    cyc(4);
    apb(1'b1, CTRL_OFS, 32'h05);
    trip_req <= 16'h0004;
    cyc(6);
    chk(cmd.run, 1'b0);
    chk(fault_code, 5'h03);
    chk(relay1, 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, INT_MASK_OFS, 32'h04);
    chk(irq, 1'b1);
    apb(1'b1, INT_STATUS_OFS, 32'h1F);
    chk(irq, 1'b0);
    trip_req <= 16'h0000;
    cyc(4);
    apb(1'b1, CTRL_OFS, 32'h105);
    $display("test fan done");
    apb(1'b1, RELAY_OFS, 32'h1B1C);
    rd(RELAY_OFS, 32'h0000_1B11);
    apb(1'b1, DIN_OFS, 32'h1C);
    apb(1'b1, RESTART_OFS, 32'h01);
    apb(1'b1, CTRL_OFS, 32'h1F);
    din <= 4'h1;
    trip_req <= 16'h0005;
    cyc(6);
    chk(cmd.freq_ref, EFREQ_RESET);
    chk(cmd.vf_mode, 1'b1);
    chk(cmd.run, 1'b1);
    chk(fault_code, 5'h00);
    chk(relay2, 1'b1);
    chk(cmd.method, METHOD_VF);
    rd(STATUS_OFS, 32'h0000_0013);
    rd(INT_STATUS_OFS, 32'h0000_0001);
    apb(1'b1, NRAMP_OFS, 32'h0010_0010);
    chk(cmd.accel_time, FIRE_RAMP);
    trip_req <= 16'h0400;
    pulses(80);
    chk(k >= 2, 1'b1);
    rd(INT_STATUS_OFS, 32'h0000_0015);
    trip_req <= 16'h0000;
    cyc(20);
    trip_req <= 16'h4000;
    cyc(6);
    pulses(60);
    chk(k, 0);
    chk(fault_code, 5'h0F);
    $display("test fire done");
    trip_req <= 16'h0000;
    cyc(4);
    apb(1'b1, FREQ_OFS, 32'h0BB8);
    apb(1'b1, CTRL_OFS, 32'h119);
    din <= 4'h0;
    cyc(6);
    chk(cmd.vf_mode, 1'b0);
    chk(cmd.freq_ref, 16'h0BB8);
    chk(cmd.accel_time, 16'h0010);
    chk(relay2, 1'b0);
    chk(cmd.method, 2'h3);
    rd(INT_STATUS_OFS, 32'h0000_0017);
    trip_req <= 16'h0001;
    cyc(6);
    chk(fault_code, 5'h01);
    chk(cmd.run, 1'b0);
    $display("test exit done");
    end_sim();
  end
endmodule : drive_run_supervisor_test
`default_nettype wire
